// [uir_consts.vh]
// Purpose: shared offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb data, each register one aligned word
// Notes:   serial timing counts are in baud-generator ticks, except break length (bits) and auto-rate (edges)
`ifndef UIR_CONSTS_VH
`define UIR_CONSTS_VH
// register byte offsets
`define UIR_OFF_MODE      8'h00
`define UIR_OFF_STATUS    8'h04
`define UIR_OFF_TXDATA    8'h08
`define UIR_OFF_RXDATA    8'h0c
`define UIR_OFF_DIVISOR   8'h10
// writable masks and reset values
`define UIR_MODE_WMASK    16'hbbff
`define UIR_STA_WMASK     16'hece0
`define UIR_MODE_RESET    16'h0000
`define UIR_STA_RESET     16'h0000
// mode register fields
`define UIR_M_EN          15
`define UIR_M_SIDL        13
`define UIR_M_INFRARED_CODEC_ENABLE        12
`define UIR_M_REQUEST_PIN_MODE       11
`define UIR_M_WAKE        7
`define UIR_M_LPBK        6
`define UIR_M_AUTO_RATE_ENABLE       5
`define UIR_M_RECEIVE_POLARITY_INVERT       4
`define UIR_M_HIGH_SPEED_SELECT        3
`define UIR_M_STOP_BIT_SELECT       0
// status register fields
`define UIR_S_TXISEL1     15
`define UIR_S_TXINV       14
`define UIR_S_TXISEL0     13
`define UIR_S_BRK         11
`define UIR_S_TXEN        10
`define UIR_S_ADDRESS_DETECT_ENABLE       5
`define UIR_S_OVERRUN_ERROR_FLAG        1
// field codes
`define UIR_PD_NINE       2'h3
`define UIR_PD_ODD        2'h2
`define UIR_PD_EVEN       2'h1
`define UIR_UEN_BCLK      2'h3
`define UIR_UEN_FLOW      2'h2
`define UIR_UEN_RTS       2'h1
`define UIR_TXI_EMPTY     2'h2
`define UIR_TXI_DONE      2'h1
`define UIR_TXI_EACH      2'h0
`define UIR_RXI_FULL      2'h3
`define UIR_RXI_3Q        2'h2
// timing counts in baud ticks; break length in bits, auto-rate in falling edges
`define UIR_LAST_STD      4'hf
`define UIR_LAST_HS       4'h3
`define UIR_HALF_STD      4'h7
`define UIR_HALF_HS       4'h1
`define UIR_IR_PULSE      4'h3
`define UIR_BRK_BITS      4'hc
`define UIR_ABD_EDGES     3'h5
`endif

// [uir_baud.v]
// Purpose: free-running baud timer giving one tick per divisor period
// Assumes: divisor write pulse arrives with the new value
// Notes:   bclk_q is high during the first half of each period
`timescale 1ns/100ps
module uir_baud (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // control
  input  wire        run,
  input  wire        div_wr,
  input  wire [15:0] div,
  // timing outputs
  output reg         tick_q,
  output reg         bclk_q
);
  reg [15:0] cnt_q;  // period counter
  ////////////////////////////////////////////////////////////////
  // counter restarts at once on a new divisor
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
      bclk_q <= 1'b0;
    end else if (div_wr) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (run) begin
      bclk_q <= (cnt_q <= {1'b0, div[15:1]});
      if (cnt_q >= div) begin
        cnt_q  <= 16'h0000;
        tick_q <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 16'h0001;
        tick_q <= 1'b0;
      end
    end else begin
      tick_q <= 1'b0;
    end
  end
endmodule // uir_baud

// [uir_fifo.v]
// Purpose: small first-in first-out queue
// Assumes: depth is a power of two
// Notes:   push when full and pop when empty are ignored
`timescale 1ns/100ps
module uir_fifo #(
  parameter W     = 9,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // control
  input  wire         flush,
  input  wire         push,
  input  wire [W-1:0] wdata,
  input  wire         pop,
  // state
  output wire [W-1:0] rdata,
  output wire [AW:0]  count,
  output wire         full,
  output wire         empty
);
  localparam [AW:0] FULLC = DEPTH;
  reg [W-1:0] mem [0:DEPTH-1]; // storage
  reg [AW-1:0] wp_q;           // write pointer
  reg [AW-1:0] rp_q;           // read pointer
  reg [AW:0]   cnt_q;          // fill level
  wire do_push = push & ~full;
  wire do_pop  = pop & ~empty;
  assign rdata = mem[rp_q];
  assign count = cnt_q;
  assign full  = (cnt_q == FULLC);
  assign empty = (cnt_q == {(AW+1){1'b0}});
  ////////////////////////////////////////////////////////////////
  // storage write, no reset needed
  always @(posedge pclk) begin
    if (do_push) begin
      mem[wp_q] <= wdata;
    end
  end
  // pointers and level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_push & ~do_pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (do_pop & ~do_push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // uir_fifo

// [uir_ctrl.v]
// Purpose: serial transceiver with infrared codec, mode and status registers
// Assumes: apb slave with no wait states; pins synchronous to pclk
// Notes:   tx/rx queues are four deep; receive entries carry their errors
`timescale 1ns/100ps
`include "uir_consts.vh"
module uir_ctrl #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW    = 2
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // chip power state
  input  wire        chip_idle,
  input  wire        chip_sleep,
  // serial pins
  input  wire        serial_in_pin,
  output reg         serial_out_pin,
  output reg         serial_out_oe,
  input  wire        clear_to_send_pin_n,
  output reg         request_to_send_pin,
  output reg         request_to_send_oe,
  // events
  output reg         tx_irq,
  output reg         rx_irq,
  output reg         wake_irq
);
  // states
  localparam [1:0] S_IDLE = 2'h0, S_START = 2'h1, S_DATA = 2'h2, S_STOP = 2'h3;

  // ticks per bit minus one
  function [3:0] bit_last;
    input hs;
    begin
      bit_last = hs ? `UIR_LAST_HS : `UIR_LAST_STD;
    end
  endfunction
  // parity bit for eight data bits
  function par_bit;
    input [7:0] d;
    input odd;
    begin
      par_bit = (^d) ^ odd;
    end
  endfunction

  reg  [15:0] mode_q;     // mode register
  reg  [15:0] sta_q;      // status control bits
  reg  [15:0] div_q;      // baud divisor
  reg         div_wr_q;   // divisor change pulse
  reg         overrun_error_flag_q;     // overrun flag
  reg         txen_q;     // previous transmit enable
  // transmitter
  reg  [1:0]  tst_q;      // tx state
  reg  [3:0]  tsub_q;     // tick within bit
  reg  [3:0]  tcnt_q;     // bits left
  reg  [11:0] tsh_q;      // tx shifter
  reg         tbrk_q;     // break frame running
  reg         tline_q;    // raw tx level
  // receiver
  reg  [1:0]  rst_q;      // rx state
  reg  [3:0]  rsub_q;     // tick within bit
  reg  [3:0]  rcnt_q;     // bits left
  reg  [8:0]  rsh_q;      // rx shifter
  reg  [3:0]  irh_q;      // infrared pulse stretch
  reg         rprev_q;    // previous line level
  // auto rate
  reg  [23:0] abd_q;      // cycle count
  reg  [2:0]  abe_q;      // falling edges seen
  reg         abw_q;      // previous auto-rate enable

  // mode and status fields
  wire        en    = mode_q[`UIR_M_EN];
  wire        infrared_codec_enable  = mode_q[`UIR_M_INFRARED_CODEC_ENABLE];
  wire        hs    = mode_q[`UIR_M_HIGH_SPEED_SELECT];
  wire [1:0]  pin_usage_select   = mode_q[9:8];
  wire [1:0]  pd    = mode_q[2:1];
  wire        nine  = (pd == `UIR_PD_NINE);
  wire        has_p = (pd == `UIR_PD_ODD) | (pd == `UIR_PD_EVEN);
  wire        auto_rate_enable = mode_q[`UIR_M_AUTO_RATE_ENABLE];
  wire [1:0]  txi   = {sta_q[`UIR_S_TXISEL1], sta_q[`UIR_S_TXISEL0]};
  wire [1:0]  rxi   = sta_q[7:6];
  wire        txen  = sta_q[`UIR_S_TXEN];
  // module runs unless disabled or halted in idle
  wire        run   = en & ~(mode_q[`UIR_M_SIDL] & chip_idle);
  wire        tick;
  wire        bclk;
  wire [3:0]  last  = bit_last(hs);
  wire [3:0]  nbits = (nine | has_p) ? 4'h9 : 4'h8;

  // apb decode
  wire        acc    = psel & penable & pready;
  wire        wr     = acc & pwrite;
  wire        setup  = psel & ~penable;
  wire        mapped = (paddr == `UIR_OFF_MODE) | (paddr == `UIR_OFF_STATUS) | (paddr == `UIR_OFF_TXDATA) |
                       (paddr == `UIR_OFF_RXDATA) | (paddr == `UIR_OFF_DIVISOR);

  // queues
  wire [8:0]  tx_head;
  wire [10:0] rx_head;
  wire [FIFO_AW:0] tx_cnt;
  wire [FIFO_AW:0] rx_cnt;
  wire        tx_full, tx_empty, rx_full, rx_empty;
  wire        tx_load = run & tick & (tst_q == S_IDLE) & txen & ~tx_empty &
                        ((pin_usage_select != `UIR_UEN_FLOW) | ~clear_to_send_pin_n);
  wire        rx_pop  = acc & ~pwrite & (paddr == `UIR_OFF_RXDATA);
  // overrun clear: software 1->0 unless a new overrun lands now
  wire        oclr    = wr & (paddr == `UIR_OFF_STATUS) & ~pwdata[`UIR_S_OVERRUN_ERROR_FLAG] & overrun_error_flag_q;
  wire        tx_flush = ~en | (txen_q & ~txen);
  reg         rx_push;
  reg  [10:0] rx_word;
  reg         ovf;
  wire        rx_flush = ~en | (oclr & ~ovf);

  // receive line: polarity, codec, loopback; transmitter busy and empty
  wire        rnorm   = serial_in_pin ^ mode_q[`UIR_M_RECEIVE_POLARITY_INVERT];
  wire        rdec    = infrared_codec_enable ? ~(~rnorm | (irh_q != 4'h0)) : rnorm;
  wire        rline   = mode_q[`UIR_M_LPBK] ? tline_q : rdec;
  wire        tx_busy = (tst_q != S_IDLE);
  wire        shift_register_empty    = ~tx_busy & tx_empty;

  uir_baud u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .div_wr  (div_wr_q),
    .div     (div_q),
    .tick_q  (tick),
    .bclk_q  (bclk)
  );

  uir_fifo #(.W(9), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txq (
    .pclk    (pclk),
    .presetn (presetn),
    .flush   (tx_flush),
    .push    (wr & (paddr == `UIR_OFF_TXDATA)),
    .wdata   (pwdata[8:0]),
    .pop     (tx_load),
    .rdata   (tx_head),
    .count   (tx_cnt),
    .full    (tx_full),
    .empty   (tx_empty)
  );

  uir_fifo #(.W(11), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rxq (
    .pclk    (pclk),
    .presetn (presetn),
    .flush   (rx_flush),
    .push    (rx_push),
    .wdata   (rx_word),
    .pop     (rx_pop),
    .rdata   (rx_head),
    .count   (rx_cnt),
    .full    (rx_full),
    .empty   (rx_empty)
  );

  ////////////////////////////////////////////////////////////////
  // received frame to queue word {framing_error_flag, parity_error_flag, data}
  always @* begin
    rx_word = {2'b00, 9'h000};
    rx_push = 1'b0;
    ovf     = 1'b0;
    if ((rst_q == S_STOP) & tick & (rsub_q == last)) begin
      if (nine) begin
        rx_word[8:0] = rsh_q;
      end else if (has_p) begin
        rx_word[8:0] = {1'b0, rsh_q[7:0]};
        rx_word[9]   = rsh_q[8] ^ par_bit(rsh_q[7:0], pd == `UIR_PD_ODD);
      end else begin
        rx_word[8:0] = {1'b0, rsh_q[8:1]};
      end
      rx_word[10] = ~rline;
      // address detect drops data characters in nine-bit mode
      rx_push = ~(sta_q[`UIR_S_ADDRESS_DETECT_ENABLE] & nine & ~rsh_q[8]);
      ovf     = rx_push & rx_full;
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb slave: registers sampled in setup, answered in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= 32'h00000000;
      if (setup) begin
        case (paddr)
          `UIR_OFF_MODE:    prdata <= {16'h0000, mode_q};
          `UIR_OFF_STATUS:  prdata <= {16'h0000, sta_q[15:11], sta_q[10], tx_full, shift_register_empty,
                                       sta_q[7:5], (rst_q == S_IDLE), rx_head[9] & ~rx_empty, rx_head[10] & ~rx_empty,
                                       overrun_error_flag_q, ~rx_empty};
          `UIR_OFF_RXDATA:  prdata <= {23'h000000, rx_head[8:0]};
          `UIR_OFF_DIVISOR: prdata <= {16'h0000, div_q};
          default:          prdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // control registers with hardware clears
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= `UIR_MODE_RESET;
      sta_q    <= `UIR_STA_RESET;
      div_q    <= 16'h0000;
      div_wr_q <= 1'b0;
      overrun_error_flag_q   <= 1'b0;
      txen_q   <= 1'b0;
    end else begin
      div_wr_q <= 1'b0;
      txen_q   <= txen;
      if (wr & (paddr == `UIR_OFF_MODE)) begin
        mode_q <= pwdata[15:0] & `UIR_MODE_WMASK;
      end else begin
        // wake clears on rising line after its edge
        if (mode_q[`UIR_M_WAKE] & rnorm & ~rprev_q) begin
          mode_q[`UIR_M_WAKE] <= 1'b0;
        end
        if (auto_rate_enable & (abe_q == `UIR_ABD_EDGES)) begin
          mode_q[`UIR_M_AUTO_RATE_ENABLE] <= 1'b0;
        end
      end
      if (wr & (paddr == `UIR_OFF_STATUS)) begin
        sta_q <= pwdata[15:0] & `UIR_STA_WMASK;
      end else if (tbrk_q & (tst_q == S_STOP) & tick & (tsub_q == last)) begin
        sta_q[`UIR_S_BRK] <= 1'b0;
      end
      if (wr & (paddr == `UIR_OFF_DIVISOR)) begin
        div_q    <= pwdata[15:0];
        div_wr_q <= 1'b1;
      end else if (auto_rate_enable & (abe_q == `UIR_ABD_EDGES)) begin
        // eight bit times measured; divide by 8 x ticks per bit
        div_q    <= hs ? (abd_q[20:5] - 16'h0001) : (abd_q[22:7] - 16'h0001);
        div_wr_q <= 1'b1;
      end
      // set wins over software clear
      if (ovf) begin
        overrun_error_flag_q <= 1'b1;
      end else if (oclr | ~en) begin
        overrun_error_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmitter: start, data lsb first, parity, stops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tst_q   <= S_IDLE;
      tsub_q  <= 4'h0;
      tcnt_q  <= 4'h0;
      tsh_q   <= 12'h000;
      tbrk_q  <= 1'b0;
      tline_q <= 1'b1;
      tx_irq  <= 1'b0;
    end else if (tx_flush) begin
      tst_q   <= S_IDLE;
      tline_q <= 1'b1;
      tbrk_q  <= 1'b0;
      tx_irq  <= 1'b0;
    end else begin
      tx_irq <= 1'b0;
      if (tx_load) begin
        tst_q   <= S_START;
        tsub_q  <= 4'h0;
        tline_q <= 1'b0;
        tbrk_q  <= sta_q[`UIR_S_BRK];
        if (sta_q[`UIR_S_BRK]) begin
          tsh_q  <= 12'h000;
          tcnt_q <= `UIR_BRK_BITS;
        end else begin
          tsh_q  <= {3'b000, has_p ? par_bit(tx_head[7:0], pd == `UIR_PD_ODD) : tx_head[8], tx_head[7:0]};
          tcnt_q <= nbits;
        end
        // event per transmit interrupt mode
        tx_irq <= (txi == `UIR_TXI_EACH) | ((txi == `UIR_TXI_EMPTY) & (tx_cnt == 1));
      end else if (run & tick) begin
        if (tsub_q != last) begin
          tsub_q <= tsub_q + 4'h1;
        end else begin
          tsub_q <= 4'h0;
          case (tst_q)
            S_START, S_DATA: begin
              if (tcnt_q == 4'h0) begin
                tst_q   <= S_STOP;
                tline_q <= 1'b1;
                tcnt_q  <= {3'b000, mode_q[`UIR_M_STOP_BIT_SELECT] & ~tbrk_q};
              end else begin
                tst_q   <= S_DATA;
                tline_q <= tsh_q[0];
                tsh_q   <= {1'b0, tsh_q[11:1]};
                tcnt_q  <= tcnt_q - 4'h1;
              end
            end
            S_STOP: begin
              if (tcnt_q == 4'h0) begin
                tst_q  <= S_IDLE;
                tbrk_q <= 1'b0;
                tx_irq <= (txi == `UIR_TXI_DONE) & tx_empty;
              end else begin
                tcnt_q <= tcnt_q - 4'h1;
              end
            end
            default: tst_q <= S_IDLE;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // receiver: mid-bit sampling, held off during rate measurement
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q  <= S_IDLE;
      rsub_q <= 4'h0;
      rcnt_q <= 4'h0;
      rsh_q  <= 9'h000;
      rx_irq <= 1'b0;
    end else if (rx_flush | auto_rate_enable) begin
      rst_q  <= S_IDLE;
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= 1'b0;
      if (rx_push & ~rx_full) begin
        case (rxi)
          `UIR_RXI_FULL: rx_irq <= (rx_cnt == FIFO_DEPTH - 1);
          `UIR_RXI_3Q:   rx_irq <= (rx_cnt == FIFO_DEPTH - 2);
          default:       rx_irq <= 1'b1;
        endcase
      end
      if (run & tick) begin
        rsub_q <= rsub_q + 4'h1;
        case (rst_q)
          S_IDLE: begin
            rsub_q <= 4'h0;
            if (~rline) begin
              rst_q <= S_START;
            end
          end
          S_START: begin
            if (rsub_q == (hs ? `UIR_HALF_HS : `UIR_HALF_STD)) begin
              rsub_q <= 4'h0;
              rcnt_q <= nbits;
              rst_q  <= rline ? S_IDLE : S_DATA;
            end
          end
          S_DATA: begin
            if (rsub_q == last) begin
              rsub_q <= 4'h0;
              rsh_q  <= {rline, rsh_q[8:1]};
              rcnt_q <= rcnt_q - 4'h1;
              if (rcnt_q == 4'h1) begin
                rst_q <= S_STOP;
              end
            end
          end
          S_STOP: begin
            if (rsub_q == last) begin
              rst_q <= S_IDLE;
            end
          end
          default: rst_q <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // infrared stretch, wake edge, auto-rate timing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irh_q    <= 4'h0;
      rprev_q  <= 1'b1;
      abd_q    <= 24'h000000;
      abe_q    <= 3'h0;
      abw_q    <= 1'b0;
      wake_irq <= 1'b0;
    end else begin
      rprev_q <= rnorm;
      if (~rnorm) begin
        irh_q <= last;
      end else if (tick & (irh_q != 4'h0)) begin
        irh_q <= irh_q - 4'h1;
      end
      // falling edge while wake armed, sampled even in sleep
      wake_irq <= mode_q[`UIR_M_WAKE] & ~rnorm & rprev_q & (chip_sleep | en);
      abw_q    <= auto_rate_enable;
      if (~auto_rate_enable | ~abw_q) begin
        abd_q <= 24'h000000;
        abe_q <= 3'h0;
      end else begin
        if (abe_q != 3'h0) begin
          abd_q <= abd_q + 24'h000001;
        end
        if (~rnorm & rprev_q) begin
          abe_q <= abe_q + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin drive: usage field, codec, request pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin      <= 1'b1;
      serial_out_oe       <= 1'b0;
      request_to_send_pin <= 1'b1;
      request_to_send_oe  <= 1'b0;
    end else begin
      serial_out_oe <= en & txen;
      if (infrared_codec_enable) begin
        // zero bits send a short pulse; invert picks idle level
        serial_out_pin <= (~tline_q & (tsub_q < `UIR_IR_PULSE)) ^ sta_q[`UIR_S_TXINV];
      end else begin
        serial_out_pin <= tline_q;
      end
      request_to_send_oe <= en & (pin_usage_select != 2'h0);
      if (pin_usage_select == `UIR_UEN_BCLK) begin
        request_to_send_pin <= bclk;
      end else if (mode_q[`UIR_M_REQUEST_PIN_MODE]) begin
        request_to_send_pin <= ~tx_busy;
      end else begin
        request_to_send_pin <= rx_full;
      end
    end
  end
endmodule // uir_ctrl

// [uir_ctrl_checker.sv]
// Purpose: port-level checks of the serial control block
// Assumes: zero-wait apb slave; events are one-cycle pulses
// Notes:   bound to every instance of the block
`timescale 1ns/100ps
module uir_ctrl_checker (
  // clock, reset and apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // events
  input wire        tx_irq,
  input wire        rx_irq,
  input wire        wake_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // answer comes exactly one cycle after setup
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  // events stand one cycle only
  tx_pulse_a: assert property (tx_irq |=> !tx_irq)
    else $error("transmit event too long");
  rx_pulse_a: assert property (rx_irq |=> !rx_irq)
    else $error("receive event too long");
  wake_pulse_a: assert property (wake_irq |=> !wake_irq)
    else $error("wake event too long");
endmodule // uir_ctrl_checker
bind uir_ctrl uir_ctrl_checker uir_ctrl_checker_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .tx_irq, .rx_irq, .wake_irq);

// [uir_peer.sv]
// Purpose: remote serial peer that sends and takes 8N1 frames
// Assumes: sixteen pclk per bit (divisor 0, standard speed)
// Notes:   line idles high, the wire has a pull-up
`timescale 1ns/100ps
module uir_peer (
  // clock
  input  wire pclk,
  // serial wires
  input  wire line_in,
  output reg  line_out
);
  initial line_out = 1'b1;
  // send one frame: start, data lsb first, one stop
  task send(input [7:0] b);
    integer i;
    begin
      line_out <= 1'b0;
      repeat (16) @(posedge pclk);
      for (i = 0; i < 8; i = i + 1) begin
        line_out <= b[i];
        repeat (16) @(posedge pclk);
      end
      line_out <= 1'b1;
      repeat (16) @(posedge pclk);
    end
  endtask
  // take one frame, sampling each bit in its middle
  task recv(output [7:0] b);
    integer i;
    begin
      @(negedge line_in);
      repeat (8) @(posedge pclk);
      for (i = 0; i < 8; i = i + 1) begin
        repeat (16) @(posedge pclk);
        b[i] = line_in;
      end
    end
  endtask
endmodule // uir_peer

// [uir_ctrl_tb.sv]
// Purpose: self-checking bench for the serial control block
// Assumes: divisor 0, so one baud tick per pclk
// Notes:   chip power inputs held inactive, clear-to-send held asserted (low)
`timescale 1ns/100ps
module uir_ctrl_tb;
  reg         pclk    = 1'b0;
  reg         presetn = 1'b0;
  reg         psel    = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite  = 1'b0;
  reg  [7:0]  paddr   = 8'h00;
  reg  [31:0] pwdata  = 32'h0;
  wire [31:0] prdata;
  wire        pready, pslverr, so, soe, rx_irq, pin_in, pin_out;
  wire        tx_irq, wake_irq, rts, rts_oe;
  reg  [31:0] r;
  reg  [7:0]  b;
  reg         e;
  integer     n_errors = 0;
  integer     samples_checked = 0;
  integer     k, j;
  integer     n_tx_irq = 0;
  integer     n_wake   = 0;
  // released transmit wire is pulled up
  assign pin_out = soe ? so : 1'b1;
  always #50 pclk = ~pclk;
  uir_ctrl uir_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_idle(1'b0), .chip_sleep(1'b0), .serial_in_pin(pin_in),
    .serial_out_pin(so), .serial_out_oe(soe), .clear_to_send_pin_n(1'b0),
    .request_to_send_pin(rts), .request_to_send_oe(rts_oe), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .wake_irq(wake_irq));
  uir_peer uir_peer_i (.pclk(pclk), .line_in(pin_out), .line_out(pin_in));
  // count event pulses so scenarios can compare totals later
  always @(posedge pclk) begin
    if (tx_irq === 1'b1) n_tx_irq <= n_tx_irq + 1;
    if (wake_irq === 1'b1) n_wake <= n_wake + 1;
  end
  //////////////////////////////////////////////////////////////////////
  // one apb transfer, held until pready is seen
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // bounded wait for the receive event
  task wirq;
    begin
      k = 0;
      while (rx_irq !== 1'b1 && k < 600) begin
        @(posedge pclk);
        k = k + 1;
      end
      chk(rx_irq, 1'b1);
    end
  endtask
  task report_and_stop;
    begin
      if (n_errors == 0 && samples_checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  // reset values, write masks, unmapped address
  task t_regs;
    begin
      apb(0, 8'h04, 0);
      chk(r, 32'h0110);
      apb(1, 8'h00, 32'h7f17);
      apb(0, 8'h00, 0);
      chk(r, 32'h3b17);
      apb(0, 8'h14, 0);
      chk(e, 1'b1);
      apb(1, 8'h10, 0);
    end
  endtask
  // frame out, queue full, abort
  task t_tx;
    begin
      apb(1, 8'h00, 32'h8000);
      apb(1, 8'h04, 32'h0400);
      repeat (2) @(posedge pclk);
      chk(soe, 1'b1);
      fork
        apb(1, 8'h08, 32'ha5);
        uir_peer_i.recv(b);
      join
      chk(b, 8'ha5);
      chk(n_tx_irq, 1);
      for (j = 0; j < 5; j = j + 1) apb(1, 8'h08, j);
      apb(0, 8'h04, 0);
      chk(r[9:8], 2'b10);
      apb(1, 8'h04, 0);
      apb(0, 8'h04, 0);
      chk(r[9:8], 2'b01);
      chk(soe, 1'b0);
    end
  endtask
  // loopback returns the frame
  task t_loop;
    begin
      apb(1, 8'h00, 32'h8140);
      apb(1, 8'h04, 32'h0400);
      fork
        apb(1, 8'h08, 32'h5a);
        wirq;
      join
      apb(0, 8'h0c, 0);
      chk(r, 32'h5a);
      chk({rts_oe, rts}, 2'b10);
    end
  endtask
  // receive one frame from the peer
  task t_rx;
    begin
      apb(1, 8'h00, 32'h8080);
      fork
        uir_peer_i.send(8'h3c);
        wirq;
      join
      apb(0, 8'h04, 0);
      chk(r[4:0], 5'h11);
      apb(0, 8'h00, 0);
      chk(r, 32'h8000);
      chk(n_wake, 1);
      chk(rts_oe, 1'b0);
      apb(0, 8'h0c, 0);
      chk(r, 32'h3c);
      apb(0, 8'h04, 0);
      chk(r[0], 1'b0);
    end
  endtask
  // fifth char overruns; clearing flag empties queue
  task t_ovr;
    begin
      for (j = 0; j < 4; j = j + 1) fork
        uir_peer_i.send(j[7:0]);
        wirq;
      join
      uir_peer_i.send(8'h99);
      repeat (4) @(posedge pclk);
      apb(0, 8'h04, 0);
      chk(r[1:0], 2'b11);
      apb(1, 8'h04, 32'h0400);
      apb(0, 8'h04, 0);
      chk(r[1:0], 2'b00);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_tx;
    t_loop;
    t_rx;
    t_ovr;
    report_and_stop;
  end
  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors = n_errors + 1;
    report_and_stop;
  end
endmodule // uir_ctrl_tb
